// File: inc/snsreg_consts.svh
`ifndef SNSREG_CONSTS_SVH
`define SNSREG_CONSTS_SVH

`define SNSREG_ADDR_OBS        7'h3D
`define SNSREG_ADDR_INV_ID     7'h3F
`define SNSREG_ADDR_PIXEL      7'h40
`define SNSREG_ADDR_MOTION     7'h50
`define SNSREG_ADDR_FW_LOAD    7'h60
`define SNSREG_OBS_RESET       8'h00
`define SNSREG_OBS_FW_BIT      7
`define SNSREG_OBS_PD_BIT      5
`define SNSREG_OBS_TICK_A_BIT  1
`define SNSREG_OBS_TICK_B_BIT  0
`define SNSREG_OBS_STORED_MASK 8'h23
`define SNSREG_PIXEL_RESET     8'h00
`define SNSREG_BYTE_BITS       4'h8
`define SNSREG_FIFO_DEPTH      4
`define SNSREG_SYNC_STAGES     2

`endif

// File: inc/snsreg_pkg.sv
package snsreg_pkg;
  typedef struct packed {
    logic [7:0] data;
  } snsreg_byte_t;

  typedef enum logic [2:0] {
    SNSREG_NONE   = 3'b001,
    SNSREG_PIXEL  = 3'b010,
    SNSREG_MOTION = 3'b100
  } snsreg_burst_t;

  typedef enum logic [2:0] {
    SNSREG_ST_IDLE = 3'b001,
    SNSREG_ST_ADDR = 3'b010,
    SNSREG_ST_DATA = 3'b100
  } snsreg_state_t;

  typedef struct packed {
    logic ncs;
    logic sclk;
    logic mosi;
    logic pd_n;
  } snsreg_pins_t;
endpackage : snsreg_pkg

// File: hw/snsreg_top.sv
`timescale 1ns/1ps
`include "snsreg_consts.svh"

module snsreg_fifo
  import snsreg_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SNSREG_FIFO_DEPTH
) (
  input  wire logic             clk,       // core clock
  input  wire logic             rst,       // sync reset
  input  wire logic [WIDTH-1:0] in_data,   // fill data
  input  wire logic             in_valid,  // fill valid
  output logic                  in_ready,  // not full
  output logic      [WIDTH-1:0] out_data,  // head word
  output logic                  out_valid, // not empty
  input  wire logic             out_ready  // drain
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (wr_ff - rd_ff) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ff != rd_ff;
  assign out_data  = mem_ff[rd_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule : snsreg_fifo

// Functional notes
// - observation register at 0x3D is read/write and resets to zero.
// - flags are re-set by their processes; bits 1 and 0 once per frame.
// - any still-active process re-sets its flag before the controller reads.
// - observation bit 7 reads one while shadow firmware runs, else zero.
// - observation bit 5 sets on a detected power-down pulse, else reads zero.
// - register 0x3F returns the bitwise inverse of the part identifier.
// - reading 0x40 streams pixel bytes in a burst; resets to zero.
// - reading 0x50 streams the motion record bytes in a single burst.
// - 0x60 is write-only; written bytes feed shadow program memory loading.
module snsreg_top
  import snsreg_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5A  // arbitrary neutral value
) (
  input  wire logic          clk,              // 125 MHz core clock
  input  wire logic          rst,              // sync reset, active high
  input  wire logic          ncs_n,            // serial chip select, pin
  input  wire logic          sclk,             // serial clock, pin
  input  wire logic          mosi,             // serial data in, pin
  output logic               miso,             // serial data out
  output logic               miso_oe,          // miso driven while selected
  input  wire logic          powerdown_n_input,// power-down pin
  input  wire logic          frame_tick,       // one pulse per frame
  input  wire logic          firmware_running, // shadow firmware executing
  input  wire snsreg_byte_t  stream_data,      // burst source byte
  input  wire logic          stream_valid,     // burst source valid
  output logic               stream_ready,     // fifo has room
  output snsreg_burst_t      burst_sel,        // which burst is open
  output snsreg_byte_t       fw_byte,          // firmware byte
  output logic               fw_byte_valid     // one-cycle strobe
);
  snsreg_pins_t  pins_q1_ff;
  snsreg_pins_t  pins_q2_ff;
  logic          sclk_d_ff;
  logic          pd_d_ff;
  snsreg_state_t state_ff;
  logic [3:0]    bit_cnt_ff;
  logic [7:0]    rx_sh_ff;
  logic [7:0]    tx_sh_ff;
  logic [6:0]    addr_ff;
  logic          wr_ff;
  logic [7:0]    obs_ff;
  logic          fifo_ready_ff;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          byte_done;
  logic [7:0]    nxt_rx;
  logic [7:0]    rd_data;
  logic          obs_wr;
  logic          fifo_pop;
  logic          fifo_in_ready;
  snsreg_byte_t  fifo_out;
  logic          fifo_out_valid;

  // pins cross in through two flops; only stage two is looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      pins_q1_ff <= '{ncs: 1'b1, sclk: 1'b1, mosi: 1'b0, pd_n: 1'b1};
      pins_q2_ff <= '{ncs: 1'b1, sclk: 1'b1, mosi: 1'b0, pd_n: 1'b1};
      sclk_d_ff  <= 1'b1;
      pd_d_ff    <= 1'b1;
    end else begin
      pins_q1_ff <= '{ncs: ncs_n, sclk: sclk, mosi: mosi, pd_n: powerdown_n_input};
      pins_q2_ff <= pins_q1_ff;
      sclk_d_ff  <= pins_q2_ff.sclk;
      pd_d_ff    <= pins_q2_ff.pd_n;
    end
  end

  assign sclk_rise = !pins_q2_ff.ncs && pins_q2_ff.sclk && !sclk_d_ff;
  assign sclk_fall = !pins_q2_ff.ncs && !pins_q2_ff.sclk && sclk_d_ff;
  assign nxt_rx    = {rx_sh_ff[6:0], pins_q2_ff.mosi};
  assign byte_done = sclk_rise && (bit_cnt_ff == `SNSREG_BYTE_BITS - 4'h1);
  assign obs_wr    = byte_done && (state_ff == SNSREG_ST_DATA) && wr_ff && (addr_ff == `SNSREG_ADDR_OBS);

  // burst ports pop a fresh byte each time the next byte is loaded;
  // the address byte decodes itself since burst_sel opens one edge later
  assign fifo_pop = byte_done &&
                    ((state_ff == SNSREG_ST_DATA) ? (!wr_ff && burst_sel != SNSREG_NONE) :
                     (!nxt_rx[7] && (nxt_rx[6:0] == `SNSREG_ADDR_PIXEL ||
                                     nxt_rx[6:0] == `SNSREG_ADDR_MOTION)));

  always_comb begin
    rd_data = 8'h00;  // reserved addresses read zero
    case (state_ff == SNSREG_ST_ADDR ? nxt_rx[6:0] : addr_ff)
      `SNSREG_ADDR_OBS: begin
        rd_data = obs_ff & `SNSREG_OBS_STORED_MASK;  // reserved bits zero
        rd_data[`SNSREG_OBS_FW_BIT] = firmware_running;
      end
      `SNSREG_ADDR_INV_ID: rd_data = ~PART_ID;
      `SNSREG_ADDR_PIXEL,
      `SNSREG_ADDR_MOTION: rd_data = fifo_out_valid ? fifo_out.data : `SNSREG_PIXEL_RESET;
      default: rd_data = 8'h00;  // includes write-only firmware port
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || pins_q2_ff.ncs) begin
      state_ff   <= rst ? SNSREG_ST_IDLE : SNSREG_ST_ADDR;
      bit_cnt_ff <= 4'h0;
      rx_sh_ff   <= 8'h00;
      addr_ff    <= 7'h00;
      wr_ff      <= 1'b0;
    end else if (sclk_rise) begin
      rx_sh_ff   <= nxt_rx;
      bit_cnt_ff <= byte_done ? 4'h0 : bit_cnt_ff + 4'h1;
      if (byte_done && state_ff != SNSREG_ST_DATA) begin
        addr_ff  <= nxt_rx[6:0];
        wr_ff    <= nxt_rx[7];
        state_ff <= SNSREG_ST_DATA;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || pins_q2_ff.ncs) begin
      tx_sh_ff <= 8'h00;
    end else if (byte_done) begin
      tx_sh_ff <= (state_ff == SNSREG_ST_DATA && burst_sel == SNSREG_NONE) ? 8'h00 : rd_data;
    end else if (sclk_fall) begin
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= !pins_q2_ff.ncs;
      if (sclk_fall) miso <= tx_sh_ff[7];
    end
  end

  // burst stays open until chip select rises
  always_ff @(posedge clk) begin
    if (rst || pins_q2_ff.ncs) begin
      burst_sel <= SNSREG_NONE;
    end else if (byte_done && state_ff == SNSREG_ST_ADDR && !nxt_rx[7]) begin
      case (nxt_rx[6:0])
        `SNSREG_ADDR_PIXEL:  burst_sel <= SNSREG_PIXEL;
        `SNSREG_ADDR_MOTION: burst_sel <= SNSREG_MOTION;
        default:             burst_sel <= SNSREG_NONE;
      endcase
    end
  end

  // set wins over a clearing write so no frame or pulse is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      obs_ff <= `SNSREG_OBS_RESET;
    end else begin
      if (obs_wr) obs_ff <= nxt_rx & `SNSREG_OBS_STORED_MASK;
      if (frame_tick) begin
        obs_ff[`SNSREG_OBS_TICK_A_BIT] <= 1'b1;
        obs_ff[`SNSREG_OBS_TICK_B_BIT] <= 1'b1;
      end
      if (pd_d_ff && !pins_q2_ff.pd_n) obs_ff[`SNSREG_OBS_PD_BIT] <= 1'b1;
    end
  end

  // firmware bytes stream while the write burst stays selected
  always_ff @(posedge clk) begin
    if (rst) begin
      fw_byte       <= '0;
      fw_byte_valid <= 1'b0;
    end else begin
      fw_byte_valid <= byte_done && state_ff == SNSREG_ST_DATA && wr_ff && addr_ff == `SNSREG_ADDR_FW_LOAD;
      if (byte_done) fw_byte <= '{data: nxt_rx};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fifo_ready_ff <= 1'b0;
    end else begin
      fifo_ready_ff <= fifo_in_ready;
    end
  end
  assign stream_ready = fifo_ready_ff;

  snsreg_fifo #(
    .WIDTH (8),
    .DEPTH (`SNSREG_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (stream_data.data),
    .in_valid  (stream_valid && fifo_ready_ff && fifo_in_ready),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out.data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );
endmodule : snsreg_top

// File: tb/snsreg_mcu.sv
`timescale 1ns/1ps
module snsreg_mcu (
  input  wire logic clk,   // core clock
  input  wire logic miso,  // device data
  output logic      ncs_n, // select
  output logic      sclk,  // idles high
  output logic      mosi   // to device
);
  initial begin
    ncs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end
  // released line keeps moving so a stale bit never passes
  always @(negedge clk) if (ncs_n) mosi = ~mosi;
  task automatic sel(input logic on);
    ncs_n = ~on;
    repeat (6) @(negedge clk);
  endtask : sel
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      repeat (5) @(negedge clk);
      sclk = 1'b1;
      rx[i] = miso;
      repeat (5) @(negedge clk);
    end
  endtask : xb
endmodule : snsreg_mcu

// File: tb/snsreg_assertions.sv
`timescale 1ns/1ps
module snsreg_chk
  import snsreg_pkg::*;
(
  input wire logic          clk,          // clock
  input wire logic          rst,          // reset
  input wire logic          ncs_n,        // select
  input wire logic          sclk,         // serial clock
  input wire logic          miso,         // data out
  input wire logic          miso_oe,      // out enable
  input wire snsreg_burst_t burst_sel,    // open burst
  input wire logic          fw_byte_valid // fw strobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |-> burst_sel == SNSREG_NONE && !miso_oe) else $error("reset");
  a_fw_single: assert property (fw_byte_valid |=> !fw_byte_valid) else $error("fw strobe long");
  a_fw_no_burst: assert property (fw_byte_valid |-> burst_sel == SNSREG_NONE) else $error("fw in burst");
  a_burst_onehot: assert property ($onehot(burst_sel)) else $error("burst code");
  // six samples cover the two-flop sync plus the register
  a_burst_close: assert property (ncs_n [*6] |-> burst_sel == SNSREG_NONE) else $error("burst open");
  a_oe_idle: assert property (ncs_n [*6] |-> !miso_oe) else $error("oe idle");
  a_oe_select: assert property (!ncs_n [*6] |-> miso_oe) else $error("oe select");
  a_miso_fall: assert property (miso_oe && $changed(miso) |-> !sclk) else $error("miso edge");
  c_fw: cover property (fw_byte_valid);
  c_pixel: cover property (burst_sel == SNSREG_PIXEL);
  c_motion: cover property (burst_sel == SNSREG_MOTION);
endmodule : snsreg_chk
bind snsreg_top snsreg_chk snsreg_chk_inst (.clk, .rst, .ncs_n, .sclk, .miso, .miso_oe, .burst_sel,
  .fw_byte_valid);

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import snsreg_pkg::*;
;
  localparam logic [7:0] ID = 8'h5A; // arbitrary value
  logic          clk = 1'b0, rst = 1'b1, pd_n = 1'b1, tick = 1'b0;
  logic          fw_run = 1'b0, s_valid = 1'b0;
  logic          ncs_n, sclk, mosi, miso, miso_oe, s_ready, fw_v;
  logic [7:0]    r, fwl = 8'h00;
  snsreg_byte_t  s_data = '0, fw_b;
  snsreg_burst_t bsel;
  int            errors = 0, tests_run = 0;
  always #4 clk = ~clk;
  snsreg_top #(.PART_ID(ID)) snsreg_top_inst (.clk, .rst, .ncs_n, .sclk, .mosi, .miso, .miso_oe,
    .powerdown_n_input(pd_n), .frame_tick(tick), .firmware_running(fw_run), .stream_data(s_data),
    .stream_valid(s_valid), .stream_ready(s_ready), .burst_sel(bsel), .fw_byte(fw_b), .fw_byte_valid(fw_v));
  // no pull on miso: while released the controller sees the inverse of the last bit
  snsreg_mcu snsreg_mcu_inst (.clk, .miso(miso_oe ? miso : ~miso), .ncs_n, .sclk, .mosi);
  always @(posedge clk) if (fw_v === 1'b1) fwl <= fw_b.data;
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  task automatic report_and_stop;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, w);
    snsreg_mcu_inst.sel(1'b1);
    snsreg_mcu_inst.xb(a, r);
    snsreg_mcu_inst.xb(w, r);
    snsreg_mcu_inst.sel(1'b0);
  endtask : xfer
  task automatic rd(input logic [7:0] a, e);
    xfer(a, 8'h00);
    chk("reg", e, r);
  endtask : rd
  task automatic t_regs;
    rd(8'h3D, 8'h00);
    rd(8'h3F, ~ID);
    rd(8'h3E, 8'h00);
    rd(8'h60, 8'h00);
    xfer(8'hE0, 8'h3C);
    chk("fw", 8'h3C, fwl);
  endtask : t_regs
  task automatic t_obs;
    xfer(8'hBD, 8'h00);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    pd_n = 1'b0;
    repeat (4) @(negedge clk);
    pd_n = 1'b1;
    fw_run = 1'b1;
    rd(8'h3D, 8'hA3);
    fw_run = 1'b0;
    xfer(8'hBD, 8'hFF);
    rd(8'h3D, 8'h23);
  endtask : t_obs
  task automatic t_burst(input logic [7:0] a, input snsreg_burst_t s, input int n);
    for (int i = 0; i < n; i++) begin
      s_data.data = 8'h11 + 8'(i);
      s_valid = 1'b1;
      @(negedge clk);
    end
    s_valid = 1'b0;
    repeat (3) @(negedge clk);
    chk("ready", 8'(n < 4), s_ready);
    snsreg_mcu_inst.sel(1'b1);
    snsreg_mcu_inst.xb(a, r);
    chk("bsel", s, bsel);
    for (int i = 0; i <= n; i++) begin
      snsreg_mcu_inst.xb(8'h00, r);
      chk("burst", i < n ? 8'h11 + 8'(i) : 8'h00, r);
    end
    snsreg_mcu_inst.sel(1'b0);
    chk("bsel", SNSREG_NONE, bsel);
  endtask : t_burst
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    t_regs();
    t_obs();
    t_burst(8'h40, SNSREG_PIXEL, 4);
    t_burst(8'h50, SNSREG_MOTION, 2);
    report_and_stop();
  end
endmodule : tb_top
